// >>> src/spcc_pkg.sv
package spcc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are indices; byte address is four times the index
  localparam logic [15:0] SYS_CTRL_IDX  = 16'hD002;
  localparam logic [15:0] PLL_CFG_IDX   = 16'hD004;
  localparam logic [31:0] SYS_CTRL_ADDR = {14'h0000, SYS_CTRL_IDX, 2'h0};
  localparam logic [31:0] PLL_CFG_ADDR  = {14'h0000, PLL_CFG_IDX, 2'h0};

  localparam logic [15:0] SYS_CTRL_RST   = 16'h0000;
  localparam logic [31:0] PLL_CFG_RST    = 32'h0003_8080;
  localparam logic [15:0] SYS_CTRL_WMASK = 16'h01FB;
  localparam logic [31:0] PLL_CFG_WMASK  = 32'h000F_F3F3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned STOP_BIT   = 0;
  localparam int unsigned IDLE_BIT   = 1;
  localparam int unsigned DIV_LSB    = 3;
  localparam int unsigned DIV_MSB    = 5;
  localparam int unsigned SRC_BIT    = 6;
  localparam int unsigned PLL_POWER_ENABLE_BIT  = 7;
  localparam int unsigned GIE_BIT    = 8;
  localparam int unsigned MAIN_LSB   = 12;
  localparam int unsigned MAIN_MSB   = 19;
  localparam int unsigned PRE_LSB    = 4;
  localparam int unsigned PRE_MSB    = 9;
  localparam int unsigned POST_LSB   = 0;
  localparam int unsigned POST_MSB   = 1;

  // ****************************************************************
  // Divide codes, PLL factors, timing
  // ****************************************************************
  localparam logic [2:0] DIV_BY16 = 3'h0;
  localparam logic [2:0] DIV_BY8  = 3'h1;
  localparam logic [2:0] DIV_BY2  = 3'h2;
  localparam logic [2:0] DIV_BY1  = 3'h3;
  localparam logic [8:0] M_OFFSET = 9'h008;
  localparam logic [6:0] P_OFFSET = 7'h02;
  localparam int unsigned FLASH_DELAY_MCLK = 32;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       gie;
    logic       pll_on;
    logic       src_pll;
    logic [2:0] div_sel;
    logic       unused2;
    logic       idle;
    logic       stop;
  } spcc_sys_ctrl_t;

  typedef struct packed {
    logic [7:0] main_div;
    logic [5:0] pre_div;
    logic [1:0] post_div;
  } spcc_pll_cfg_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_STOP,
    PWR_IDLE,
    PWR_FLASH_WAKE
  } spcc_pwr_state_t;

endpackage

// >>> src/spcc_mclk_div.sv
module spcc_mclk_div (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [2:0] div_sel_i,
  output logic            tick_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [3:0] last;

  // ****************************************************************
  // Divide ratio minus one
  // ****************************************************************
  always_comb begin
    unique case (div_sel_i)
      spcc_pkg::DIV_BY16: last = 4'hF;
      spcc_pkg::DIV_BY8:  last = 4'h7;
      spcc_pkg::DIV_BY2:  last = 4'h1;
      default:            last = 4'h0;
    endcase
  end

  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run_i) begin
      cnt_nxt = 4'h0;
    end else if (cnt_r >= last) begin
      cnt_nxt  = 4'h0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r  <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule

// >>> src/spcc_flash_delay.sv
module spcc_flash_delay #(
  parameter int unsigned CYCLES = spcc_pkg::FLASH_DELAY_MCLK
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  input  wire logic tick_i,
  output logic      done_o
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       busy_r;
  logic       busy_nxt;
  logic       done_r;
  logic       done_nxt;

  // Counts master-clock ticks after start, then gives one done pulse
  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start_i) begin
      cnt_nxt  = 8'h00;
      busy_nxt = 1'b1;
    end else if (busy_r && tick_i) begin
      if (cnt_r == 8'(CYCLES - 1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;

endmodule

// >>> src/spcc_top.sv
// What this block does
// - STOP halts all logic and PLL; only three external interrupts wake it.
// - IDLE halts CPU and flash; other logic runs; enabled interrupts wake it.
// - Writing one to control bit 0 enters STOP.
// - Writing one to control bit 1 enters IDLE; hardware clears the bit.
// - Entering STOP switches the PLL off without a software write.
// - STOP wake restarts PLL, starts lock timer; clock source stays as set.
// - After IDLE, hardware inserts a 32 master-clock flash start-up delay.
// - Global enable bit 8 low blocks all requests; high passes masked ones.
// - Bits 5:3 divide the clock: 16, 8, 2 or 1.
// - Bit 6 selects master clock: external clock or PLL output.
// - Bit 7 powers the PLL on or off.
// - PLL output equals m times input over p times two to s.
// - PLL register holds main, pre and post dividers at fixed fields.
module spcc_top #(
  parameter int unsigned NUM_IRQ = 8
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [31:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [2:0]            external_interrupt_input_i,
  input  wire logic [2:0]            ext_irq_enable_i,
  input  wire logic [NUM_IRQ-1:0]    irq_req_i,
  input  wire logic [NUM_IRQ-1:0]    interrupt_mask_setting_i,
  output logic [NUM_IRQ-1:0]         irq_pass_o,
  output logic                       mclk_tick_o,
  output logic                       clock_source_select_o,
  output logic                       pll_power_enable_o,
  output spcc_pkg::spcc_pll_cfg_t    pll_cfg_o,
  output logic [8:0]                 pll_m_o,
  output logic [6:0]                 pll_p_o,
  output logic [1:0]                 pll_s_o,
  output logic                       lock_timer_start_o,
  output logic                       logic_halt_o,
  output logic                       cpu_halt_o,
  output logic                       flash_halt_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  spcc_pkg::spcc_pwr_state_t state_r;
  spcc_pkg::spcc_pwr_state_t state_nxt;
  spcc_pkg::spcc_sys_ctrl_t  ctrl;

  logic [15:0] sys_ctrl_r;
  logic [15:0] sys_ctrl_nxt;
  logic [31:0] pll_cfg_r;
  logic [31:0] pll_cfg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        lock_start_r;
  logic        lock_start_nxt;
  logic [2:0]  ext_meta_r;
  logic [2:0]  ext_sync_r;
  logic [2:0]  ext_meta_nxt;
  logic [2:0]  ext_sync_nxt;
  logic        setup;
  logic        access;
  logic        wr_sys;
  logic        wr_pll;
  logic [31:0] bmask;
  logic [15:0] sys_m;
  logic [31:0] pll_m;
  logic        ext_wake;
  logic        any_wake;
  logic        stop_wake;
  logic        idle_wake;
  logic        flash_start;
  logic        flash_done;
  logic        mclk_run;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic sel_sys(input logic [31:0] addr);
    sel_sys = (addr == spcc_pkg::SYS_CTRL_ADDR);
  endfunction

  function automatic logic sel_pll(input logic [31:0] addr);
    sel_pll = (addr == spcc_pkg::PLL_CFG_ADDR);
  endfunction

  function automatic logic addr_hit(input logic [31:0] addr);
    addr_hit = sel_sys(addr) || sel_pll(addr);
  endfunction

  // State decodes shared by the clock, PLL and halt outputs
  function automatic logic in_stop(input spcc_pkg::spcc_pwr_state_t st);
    in_stop = (st == spcc_pkg::PWR_STOP);
  endfunction

  function automatic logic in_idle(input spcc_pkg::spcc_pwr_state_t st);
    in_idle = (st == spcc_pkg::PWR_IDLE);
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  assign ctrl = spcc_pkg::spcc_sys_ctrl_t'(sys_ctrl_r[8:0]);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign setup     = psel_i && !penable_i;
  assign access    = psel_i && penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !addr_hit(paddr_i);
  assign bmask     = strb_mask(pstrb_i);
  assign sys_m     = spcc_pkg::SYS_CTRL_WMASK & bmask[15:0];
  assign pll_m     = spcc_pkg::PLL_CFG_WMASK & bmask;
  assign wr_sys    = access && pwrite_i && sel_sys(paddr_i);
  assign wr_pll    = access && pwrite_i && sel_pll(paddr_i);

  // Read data is captured in the setup cycle and held through access
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup) begin
      if (sel_sys(paddr_i)) begin
        prdata_nxt = {16'h0000, sys_ctrl_r};
      end else if (sel_pll(paddr_i)) begin
        prdata_nxt = pll_cfg_r;
      end else begin
        prdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata_o = prdata_r;

  // ****************************************************************
  // Wake-up inputs
  // ****************************************************************
  // External interrupt pins come from outside the clock domain
  // Only the second stage feeds the wake logic
  always_comb begin
    ext_meta_nxt = external_interrupt_input_i;
    ext_sync_nxt = ext_meta_r;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_meta_r <= 3'h0;
      ext_sync_r <= 3'h0;
    end else begin
      ext_meta_r <= ext_meta_nxt;
      ext_sync_r <= ext_sync_nxt;
    end
  end

  assign irq_pass_o = irq_req_i & interrupt_mask_setting_i & {NUM_IRQ{ctrl.gie}};
  assign ext_wake   = ctrl.gie && |(ext_sync_r & ext_irq_enable_i);
  assign any_wake   = ext_wake || |irq_pass_o;

  // ****************************************************************
  // Power-mode state machine
  // ****************************************************************
  always_comb begin
    state_nxt      = state_r;
    lock_start_nxt = 1'b0;
    unique case (state_r)
      spcc_pkg::PWR_RUN: begin
        if (ctrl.stop) begin
          state_nxt = spcc_pkg::PWR_STOP;
        end else if (ctrl.idle) begin
          state_nxt = spcc_pkg::PWR_IDLE;
        end
      end
      spcc_pkg::PWR_STOP: begin
        if (ext_wake) begin
          state_nxt      = spcc_pkg::PWR_RUN;
          lock_start_nxt = 1'b1;
        end
      end
      spcc_pkg::PWR_IDLE: begin
        if (any_wake) begin
          state_nxt = spcc_pkg::PWR_FLASH_WAKE;
        end
      end
      spcc_pkg::PWR_FLASH_WAKE: begin
        if (flash_done) begin
          state_nxt = spcc_pkg::PWR_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r      <= spcc_pkg::PWR_RUN;
      lock_start_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      lock_start_r <= lock_start_nxt;
    end
  end

  assign stop_wake   = in_stop(state_r) && ext_wake;
  assign idle_wake   = in_idle(state_r) && any_wake;
  assign flash_start = idle_wake;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Hardware clears first; a bus write in the same cycle wins
  always_comb begin
    sys_ctrl_nxt = sys_ctrl_r;
    pll_cfg_nxt  = pll_cfg_r;
    if (stop_wake) begin
      sys_ctrl_nxt[spcc_pkg::STOP_BIT]  = 1'b0;
      sys_ctrl_nxt[spcc_pkg::PLL_POWER_ENABLE_BIT] = 1'b1;
    end
    if (idle_wake) begin
      sys_ctrl_nxt[spcc_pkg::IDLE_BIT] = 1'b0;
    end
    if (wr_sys) begin
      sys_ctrl_nxt = (sys_ctrl_nxt & ~sys_m) | (pwdata_i[15:0] & sys_m);
      if (sys_m[spcc_pkg::STOP_BIT] && pwdata_i[spcc_pkg::STOP_BIT]) begin
        sys_ctrl_nxt[spcc_pkg::IDLE_BIT] = 1'b0;
      end
    end
    if (wr_pll) begin
      pll_cfg_nxt = (pll_cfg_r & ~pll_m) | (pwdata_i & pll_m);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_ctrl_r <= spcc_pkg::SYS_CTRL_RST;
      pll_cfg_r  <= spcc_pkg::PLL_CFG_RST;
    end else begin
      sys_ctrl_r <= sys_ctrl_nxt;
      pll_cfg_r  <= pll_cfg_nxt;
    end
  end

  // ****************************************************************
  // PLL control
  // ****************************************************************
  assign pll_power_enable_o = ctrl.pll_on && !in_stop(state_r);
  assign pll_cfg_o.main_div = pll_cfg_r[spcc_pkg::MAIN_MSB:spcc_pkg::MAIN_LSB];
  assign pll_cfg_o.pre_div  = pll_cfg_r[spcc_pkg::PRE_MSB:spcc_pkg::PRE_LSB];
  assign pll_cfg_o.post_div = pll_cfg_r[spcc_pkg::POST_MSB:spcc_pkg::POST_LSB];
  assign pll_m_o = {1'b0, pll_cfg_o.main_div} + spcc_pkg::M_OFFSET;
  assign pll_p_o = {1'b0, pll_cfg_o.pre_div} + spcc_pkg::P_OFFSET;
  assign pll_s_o = pll_cfg_o.post_div;
  assign lock_timer_start_o = lock_start_r;

  // ****************************************************************
  // Master clock
  // ****************************************************************
  // Source select is left untouched by wake-up
  assign clock_source_select_o = ctrl.src_pll;
  assign mclk_run = !in_stop(state_r);

  spcc_mclk_div u_div (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .run_i     (mclk_run),
    .div_sel_i (ctrl.div_sel),
    .tick_o    (mclk_tick_o)
  );

  // ****************************************************************
  // Flash start-up delay
  // ****************************************************************
  spcc_flash_delay #(
    .CYCLES (spcc_pkg::FLASH_DELAY_MCLK)
  ) u_flash (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (flash_start),
    .tick_i    (mclk_tick_o),
    .done_o    (flash_done)
  );

  // ****************************************************************
  // Halt outputs
  // ****************************************************************
  assign logic_halt_o = in_stop(state_r);
  assign cpu_halt_o   = (state_r != spcc_pkg::PWR_RUN);
  assign flash_halt_o = in_stop(state_r) ||
                        in_idle(state_r);

endmodule

// >>> tb/spcc_assertions.sv
module spcc_assertions #(
  parameter int unsigned NUM_IRQ = 8
) (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_b_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [31:0]            paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic [3:0]             pstrb_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire logic [NUM_IRQ-1:0]     irq_req_i,
  input wire logic [NUM_IRQ-1:0]     interrupt_mask_setting_i,
  input wire logic [NUM_IRQ-1:0]     irq_pass_o,
  input wire logic                   mclk_tick_o,
  input wire logic                   pll_power_enable_o,
  input wire spcc_pkg::spcc_pll_cfg_t pll_cfg_o,
  input wire logic [8:0]             pll_m_o,
  input wire logic [6:0]             pll_p_o,
  input wire logic [1:0]             pll_s_o,
  input wire logic                   lock_timer_start_o,
  input wire logic                   logic_halt_o,
  input wire logic                   cpu_halt_o,
  input wire logic                   flash_halt_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // ****************************************
  // Ticks seen during the flash start-up wait
  // ****************************************
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (flash_halt_o || !cpu_halt_o) begin
      cnt_nxt = 8'h00;
    end else if (mclk_tick_o && cnt_r != 8'hFF) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_unmapped_err: assert property (psel_i && penable_i |-> pslverr_o ==
    (paddr_i != spcc_pkg::SYS_CTRL_ADDR && paddr_i != spcc_pkg::PLL_CFG_ADDR))
    else $error("bad slave error flag");
  a_irq_gate: assert property ((irq_pass_o & ~(irq_req_i & interrupt_mask_setting_i)) == '0)
    else $error("unrequested interrupt passed");
  a_stop_enter: assert property (psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
    && pwdata_i[0] && paddr_i == spcc_pkg::SYS_CTRL_ADDR && !cpu_halt_o
    |-> ##2 logic_halt_o && !pll_power_enable_o) else $error("stop not entered");
  a_stop_halt: assert property (logic_halt_o |-> cpu_halt_o && flash_halt_o
    && !pll_power_enable_o) else $error("stop state incomplete");
  a_stop_clock: assert property (logic_halt_o && $past(logic_halt_o) |-> !mclk_tick_o)
    else $error("master clock runs in stop");
  a_lock_start: assert property ($fell(logic_halt_o) |-> ##[0:1] lock_timer_start_o)
    else $error("lock timer not started");
  a_lock_once: assert property (lock_timer_start_o |-> !logic_halt_o ##1 !lock_timer_start_o)
    else $error("lock pulse too long");
  a_pll_restart: assert property ($fell(logic_halt_o) |-> ##[0:1] pll_power_enable_o)
    else $error("pll not restarted");
  a_idle_wake: assert property (flash_halt_o && !logic_halt_o && |irq_pass_o
    |=> !flash_halt_o && cpu_halt_o) else $error("idle not woken");
  a_flash_wait: assert property ($fell(cpu_halt_o) && !$past(flash_halt_o)
    |-> cnt_r >= 8'h1F && cnt_r <= 8'h23) else $error("flash delay length wrong");
  a_pll_factors: assert property (pll_m_o == {1'b0, pll_cfg_o.main_div} + spcc_pkg::M_OFFSET
    && pll_p_o == {1'b0, pll_cfg_o.pre_div} + spcc_pkg::P_OFFSET
    && pll_s_o == pll_cfg_o.post_div) else $error("pll factors wrong");
endmodule

bind spcc_top spcc_assertions #(.NUM_IRQ(NUM_IRQ)) spcc_assertions_i (.clk_sys_i, .rst_b_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .pslverr_o,
  .irq_req_i, .interrupt_mask_setting_i, .irq_pass_o, .mclk_tick_o, .pll_power_enable_o,
  .pll_cfg_o, .pll_m_o, .pll_p_o, .pll_s_o, .lock_timer_start_o, .logic_halt_o,
  .cpu_halt_o, .flash_halt_o);

// >>> tb/spcc_tb.sv
module spcc_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] SA = spcc_pkg::SYS_CTRL_ADDR;
  localparam logic [31:0] PA = spcc_pkg::PLL_CFG_ADDR;
  // 150 us of PLL settling at 25 ns per cycle
  localparam int PLL_WAIT = 6000;
  logic        clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i, lk;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rnd;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, tick_o, src_o, pwr_o, lock_o, lhalt_o, chalt_o, fhalt_o;
  logic [2:0]  ext_i, ext_en_i;
  logic [7:0]  req_i, mask_i, pass_o;
  logic [8:0]  m_o;
  logic [6:0]  p_o;
  logic [1:0]  s_o;
  logic [32:0] exp_q[$];
  spcc_pkg::spcc_pll_cfg_t cfg_o;
  int num_errors, checked, cyc, n;
  int dv[4] = '{16, 8, 2, 1};

  spcc_top #(.NUM_IRQ(8)) spcc_top_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .external_interrupt_input_i(ext_i), .ext_irq_enable_i(ext_en_i),
    .irq_req_i(req_i), .interrupt_mask_setting_i(mask_i), .irq_pass_o(pass_o),
    .mclk_tick_o(tick_o), .clock_source_select_o(src_o), .pll_power_enable_o(pwr_o),
    .pll_cfg_o(cfg_o), .pll_m_o(m_o), .pll_p_o(p_o), .pll_s_o(s_o),
    .lock_timer_start_o(lock_o), .logic_halt_o(lhalt_o), .cpu_halt_o(chalt_o),
    .flash_halt_o(fhalt_o));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checked=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic neg(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  task automatic gap(output int g);
    g = 0;
    neg(1);
    while (tick_o !== 1'b1) neg(1);
    do begin
      neg(1);
      g++;
    end while (tick_o !== 1'b1);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      check({pslverr_o, prdata_o}, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {ext_i, ext_en_i, req_i, mask_i} = '0;
    pstrb_i = 4'hF;
    rnd = 32'h6F86DCBA;
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(SA, 33'h0);
    rd(PA, {1'b0, spcc_pkg::PLL_CFG_RST});
    rd(32'h0003_4000, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, PA, rnd);
      rd(PA, {1'b0, rnd & spcc_pkg::PLL_CFG_WMASK});
      neg(1);
      check({24'h0, m_o}, {25'h0, rnd[19:12]} + 33'h8);
      check({26'h0, p_o}, {27'h0, rnd[9:4]} + 33'h2);
      check({31'h0, s_o}, {31'h0, rnd[1:0]});
      check({17'h0, cfg_o}, {17'h0, rnd[19:12], rnd[9:4], rnd[1:0]});
    end
    apb(1'b1, PA, spcc_pkg::PLL_CFG_RST);
    repeat (PLL_WAIT) @(posedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SA, {24'h0, i[1], i[0], i[2:0], 3'h0});
      gap(n);
      gap(n);
      check({1'b0, 32'(n)}, {1'b0, 32'(dv[i])});
      check({31'h0, pwr_o, src_o}, {31'h0, i[1], i[0]});
    end
    @(posedge clk_sys_i);
    rnd = lfsr(rnd);
    req_i <= rnd[7:0] | 8'h01;
    mask_i <= rnd[15:8] | 8'h01;
    neg(1);
    check({25'h0, pass_o}, 33'h0);
    apb(1'b1, SA, 32'h0000_0118);
    neg(1);
    check({25'h0, pass_o}, {25'h0, (rnd[7:0] | 8'h01) & (rnd[15:8] | 8'h01)});
    @(posedge clk_sys_i);
    req_i <= 8'h00;
    mask_i <= 8'hFF;
    apb(1'b1, SA, 32'h0000_011A);
    neg(8);
    check({31'h0, chalt_o, fhalt_o}, 33'h3);
    @(posedge clk_sys_i);
    req_i <= 8'h01;
    neg(3);
    check({32'h0, fhalt_o}, 33'h0);
    n = 3;
    while (chalt_o === 1'b1 && n < 100) begin
      neg(1);
      n++;
    end
    check({32'h0, n >= 33 && n <= 37}, 33'h1);
    @(posedge clk_sys_i);
    req_i <= 8'h00;
    ext_en_i <= 3'h4;
    rd(SA, 33'h118);
    apb(1'b1, SA, 32'h0000_0198);
    apb(1'b1, SA, 32'h0000_019B);
    neg(2);
    check({30'h0, lhalt_o, pwr_o, chalt_o}, 33'h5);
    @(posedge clk_sys_i);
    req_i <= 8'h01;
    n = 0;
    repeat (20) begin
      neg(1);
      n += int'(tick_o === 1'b1);
    end
    check({1'b0, 32'(n)}, 33'h0);
    check({32'h0, lhalt_o}, 33'h1);
    @(posedge clk_sys_i);
    ext_i <= 3'h4;
    n = 0;
    while (lhalt_o !== 1'b0 && n < 20) begin
      neg(1);
      n++;
    end
    lk = lock_o;
    neg(1);
    lk = lk | lock_o;
    check({32'h0, lk && n <= 6}, 33'h1);
    check({30'h0, pwr_o, src_o, chalt_o}, 33'h4);
    @(posedge clk_sys_i);
    {ext_i, ext_en_i, req_i} <= '0;
    rd(SA, 33'h198);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(SA, 33'h0);
    neg(2);
    print_verdict();
  end
endmodule
